/* hdl/gsr_defines.vh */
`ifndef GSR_DEFINES_VH
`define GSR_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define GSR_ADDR_OUTPUT_PIN_CFG 8'h0C
`define GSR_ADDR_INPUT_PIN_CFG 8'h0D
`define GSR_ADDR_PIN_VALUE_MONITOR 8'h0E
`define GSR_ADDR_SERIAL_PORT_ROUTING 8'h0F

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define GSR_RST_OUTPUT_PIN_CFG 8'h00
`define GSR_RST_INPUT_PIN_CFG 8'h00
`define GSR_RST_PIN_VALUE_MONITOR 8'h00
`define GSR_RST_SERIAL_PORT_ROUTING 8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define GSR_OUTPIN_FUNC_HI 7
`define GSR_OUTPIN_FUNC_LO 4
`define GSR_OUTPIN_RSVD_BIT 3
`define GSR_OUTPIN_DRIVE_HI 2
`define GSR_OUTPIN_DRIVE_LO 0
`define GSR_INPIN_ENABLE_BIT 1
`define GSR_INPIN_RSVD_BIT 0
`define GSR_VAL_BIDIR_A_OUT 7
`define GSR_VAL_BIDIR_B_OUT 6
`define GSR_VAL_OUTPIN_OUT 5
`define GSR_MON_BIDIR_A 3
`define GSR_MON_BIDIR_B 2
`define GSR_MON_INPIN 1
`define GSR_ROUTE_CONTROL_CLOCK_HI 6
`define GSR_ROUTE_CONTROL_CLOCK_LO 5
`define GSR_ROUTE_DIN2_HI 4
`define GSR_ROUTE_DIN2_LO 2
`define GSR_ROUTE_BCLK_BIT 1
`define GSR_ROUTE_FSYNC_BIT 0

// ------------------------------------------------------------
// drive style codes
// ------------------------------------------------------------
`define GSR_DRV_HIZ 3'h0
`define GSR_DRV_PUSH_PULL 3'h1
`define GSR_DRV_LOW_WEAKHIGH 3'h2
`define GSR_DRV_LOW_ONLY 3'h3
`define GSR_DRV_WEAKLOW_HIGH 3'h4
`define GSR_DRV_HIGH_ONLY 3'h5

// ------------------------------------------------------------
// function selector codes
// ------------------------------------------------------------
`define GSR_FUNC_DISABLED 4'h0
`define GSR_FUNC_INPUT 4'h1
`define GSR_FUNC_GPO 4'h2
`define GSR_FUNC_PRI_DOUT 4'h5
`define GSR_FUNC_PRI_DOUT2 4'h6
`define GSR_FUNC_SEC_DOUT 4'h7
`define GSR_FUNC_SEC_DOUT2 4'h8
`define GSR_FUNC_DOUT_MUXED 4'hC
`define GSR_FUNC_DAISY 4'hD

// ------------------------------------------------------------
// routing source codes
// ------------------------------------------------------------
`define GSR_SRC_OFF 3'h0
`define GSR_SRC_BIDIR_A 3'h1
`define GSR_SRC_BIDIR_B 3'h2
`define GSR_SRC_INPIN 3'h3
`define GSR_SRC_DOUT_PIN 3'h4
`define GSR_SRC_PRI_DIN 3'h5

// ------------------------------------------------------------
// synchroniser stage count
// ------------------------------------------------------------
`define GSR_SYNC_STAGES 3

`endif

/* hdl/gsr_pin_sync.v */
`timescale 1ns/1ps
`include "gsr_defines.vh"

// ------------------------------------------------------------
// per-bit pin synchroniser with agreement filter
// ------------------------------------------------------------
module gsr_pin_sync #(
  parameter WIDTH = 7
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // raw pins and clean levels
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stage2;
      reg stage3;
      reg level;
      // first flop only feeds the second; level moves once stages two and three agree
      always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          meta <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          level <= 1'b0;
        end else begin
          meta <= pin_in[i];
          stage2 <= meta;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            level <= stage3;
          end
        end
      end
      assign level_out[i] = level;
    end
  endgenerate

endmodule

/* hdl/gsr_gpio_routing.v */
`timescale 1ns/1ps
`include "gsr_defines.vh"

module gsr_gpio_routing (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // mode and function selections held elsewhere
  input wire spi_mode_in,
  input wire spi_sdo_in,
  input wire [3:0] bidir_a_function_sel_in,
  input wire [3:0] bidir_b_function_sel_in,
  input wire [15:0] outpin_func_src_in,
  // bidirectional pin a
  input wire bidir_pin_a_in,
  output reg bidir_pin_a_out,
  output reg bidir_pin_a_oe_out,
  // bidirectional pin b
  input wire bidir_pin_b_in,
  output reg bidir_pin_b_out,
  output reg bidir_pin_b_oe_out,
  // dedicated output pin
  output reg dedicated_out_pin_out,
  output reg dedicated_out_pin_oe_out,
  output reg dedicated_out_pin_weak_out,
  // dedicated input pin
  input wire dedicated_in_pin_in,
  output reg chip_select_n_out,
  // serial audio pins and secondary port
  input wire bitclk_pin_in,
  input wire framesync_pin_in,
  input wire dout_pin_in,
  input wire primary_din_pin_in,
  input wire secondary_bitclk_in,
  input wire secondary_framesync_in,
  // routed signals
  output reg control_clock_out,
  output reg primary_data_in2_out,
  output reg primary_bitclk_out,
  output reg primary_framesync_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] output_pin_cfg;
  reg [7:0] input_pin_cfg;
  reg [2:0] out_levels;
  reg [1:0] ctrl_clock_source;
  reg [2:0] primary_data_in2_source;
  reg primary_bitclk_source;
  reg primary_framesync_source;

  wire [3:0] outpin_function_sel;
  wire [2:0] outpin_drive_style;
  wire inpin_enable;
  wire bidir_a_out_level;
  wire bidir_b_out_level;
  wire outpin_out_level;

  assign outpin_function_sel = output_pin_cfg[`GSR_OUTPIN_FUNC_HI:`GSR_OUTPIN_FUNC_LO];
  assign outpin_drive_style = output_pin_cfg[`GSR_OUTPIN_DRIVE_HI:`GSR_OUTPIN_DRIVE_LO];
  assign inpin_enable = input_pin_cfg[`GSR_INPIN_ENABLE_BIT];
  assign bidir_a_out_level = out_levels[2];
  assign bidir_b_out_level = out_levels[1];
  assign outpin_out_level = out_levels[0];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [6:0] sync_level;
  wire a_sync;
  wire b_sync;
  wire in_sync;
  wire bclk_sync;
  wire fsync_sync;
  wire dout_sync;
  wire din_sync;

  // every sensed pin passes the filter before use
  gsr_pin_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in({bidir_pin_a_in, bidir_pin_b_in, dedicated_in_pin_in, bitclk_pin_in,
      framesync_pin_in, dout_pin_in, primary_din_pin_in}),
    .level_out(sync_level)
  );

  assign a_sync = sync_level[6];
  assign b_sync = sync_level[5];
  assign in_sync = sync_level[4];
  assign bclk_sync = sync_level[3];
  assign fsync_sync = sync_level[2];
  assign dout_sync = sync_level[1];
  assign din_sync = sync_level[0];

  // ------------------------------------------------------------
  // pin enables and monitor bits
  // ------------------------------------------------------------
  wire a_is_input;
  wire b_is_input;
  wire in_is_input;
  wire [7:0] monitor_view;

  assign a_is_input = (bidir_a_function_sel_in == `GSR_FUNC_INPUT);
  assign b_is_input = (bidir_b_function_sel_in == `GSR_FUNC_INPUT);
  // spi mode takes the pin over as chip select, enable bit no longer matters
  assign in_is_input = inpin_enable && !spi_mode_in;

  // each pin's monitor bit reads zero unless the pin is set up as an input; bits 7 to 5 read back the written levels
  assign monitor_view = {out_levels, 1'b0,
    a_is_input & a_sync,
    b_is_input & b_sync,
    in_is_input & in_sync,
    1'b0};

  // ------------------------------------------------------------
  // register writes and reads
  // ------------------------------------------------------------
  // reserved bits of the monitor and routing offsets are not stored; 0x0C bit 3 and 0x0D bit 0 keep what is written
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_pin_cfg <= `GSR_RST_OUTPUT_PIN_CFG;
      input_pin_cfg <= `GSR_RST_INPUT_PIN_CFG;
      out_levels <= 3'h0;
      ctrl_clock_source <= 2'h0;
      primary_data_in2_source <= 3'h0;
      primary_bitclk_source <= 1'b0;
      primary_framesync_source <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `GSR_ADDR_OUTPUT_PIN_CFG) begin
        output_pin_cfg <= reg_wdata_in;
      end else if (reg_addr_in == `GSR_ADDR_INPUT_PIN_CFG) begin
        input_pin_cfg <= {6'h00, reg_wdata_in[`GSR_INPIN_ENABLE_BIT],
          reg_wdata_in[`GSR_INPIN_RSVD_BIT]};
      end else if (reg_addr_in == `GSR_ADDR_PIN_VALUE_MONITOR) begin
        out_levels <= reg_wdata_in[`GSR_VAL_BIDIR_A_OUT:`GSR_VAL_OUTPIN_OUT];
      end else if (reg_addr_in == `GSR_ADDR_SERIAL_PORT_ROUTING) begin
        ctrl_clock_source <= reg_wdata_in[`GSR_ROUTE_CONTROL_CLOCK_HI:`GSR_ROUTE_CONTROL_CLOCK_LO];
        primary_data_in2_source <= reg_wdata_in[`GSR_ROUTE_DIN2_HI:`GSR_ROUTE_DIN2_LO];
        primary_bitclk_source <= reg_wdata_in[`GSR_ROUTE_BCLK_BIT];
        primary_framesync_source <= reg_wdata_in[`GSR_ROUTE_FSYNC_BIT];
      end
    end
  end

  // read data held until the next read; unmapped offsets answer zero
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `GSR_ADDR_OUTPUT_PIN_CFG) begin
        reg_rdata_out <= output_pin_cfg;
      end else if (reg_addr_in == `GSR_ADDR_INPUT_PIN_CFG) begin
        reg_rdata_out <= input_pin_cfg;
      end else if (reg_addr_in == `GSR_ADDR_PIN_VALUE_MONITOR) begin
        reg_rdata_out <= monitor_view;
      end else if (reg_addr_in == `GSR_ADDR_SERIAL_PORT_ROUTING) begin
        reg_rdata_out <= {1'b0, ctrl_clock_source, primary_data_in2_source,
          primary_bitclk_source, primary_framesync_source};
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // dedicated output pin
  // ------------------------------------------------------------
  reg next_out;
  reg next_oe;
  reg next_weak;
  reg outpin_level;
  reg outpin_is_audio;

  // level source, then spi mode, a disabled or audio function, or else the drive style decides strong, weak or released
  always @* begin
    outpin_level = outpin_func_src_in[outpin_function_sel];
    if (outpin_function_sel == `GSR_FUNC_GPO) begin
      outpin_level = outpin_out_level;
    end
    outpin_is_audio = (outpin_function_sel == `GSR_FUNC_PRI_DOUT) ||
      (outpin_function_sel == `GSR_FUNC_PRI_DOUT2) ||
      (outpin_function_sel == `GSR_FUNC_SEC_DOUT) ||
      (outpin_function_sel == `GSR_FUNC_SEC_DOUT2) ||
      (outpin_function_sel == `GSR_FUNC_DOUT_MUXED) ||
      (outpin_function_sel == `GSR_FUNC_DAISY);
    next_out = outpin_level;
    next_oe = 1'b0;
    next_weak = 1'b0;
    if (spi_mode_in) begin
      next_out = spi_sdo_in;
      next_oe = 1'b1;
    end else if (outpin_function_sel == `GSR_FUNC_DISABLED) begin
      next_oe = 1'b0;
    end else if (outpin_is_audio) begin
      next_oe = 1'b1;
    end else begin
      case (outpin_drive_style)
        `GSR_DRV_PUSH_PULL: begin
          next_oe = 1'b1;
        end
        `GSR_DRV_LOW_WEAKHIGH: begin
          next_oe = !outpin_level;
          next_weak = outpin_level;
        end
        `GSR_DRV_LOW_ONLY: begin
          next_oe = !outpin_level;
        end
        `GSR_DRV_WEAKLOW_HIGH: begin
          next_oe = outpin_level;
          next_weak = !outpin_level;
        end
        `GSR_DRV_HIGH_ONLY: begin
          next_oe = outpin_level;
        end
        default: begin
          // high impedance and the reserved codes release the pin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // routing muxes
  // ------------------------------------------------------------
  reg next_control_clock;
  reg next_din2;

  always @* begin
    case (ctrl_clock_source)
      2'h1: next_control_clock = a_sync;
      2'h2: next_control_clock = b_sync;
      2'h3: next_control_clock = in_sync;
      default: next_control_clock = 1'b0;
    endcase
    case (primary_data_in2_source)
      `GSR_SRC_BIDIR_A: next_din2 = a_sync;
      `GSR_SRC_BIDIR_B: next_din2 = b_sync;
      `GSR_SRC_INPIN: next_din2 = in_sync;
      `GSR_SRC_DOUT_PIN: next_din2 = dout_sync;
      `GSR_SRC_PRI_DIN: next_din2 = din_sync;
      default: next_din2 = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  // all pins and routed signals leave from flops to keep them glitch free
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bidir_pin_a_out <= 1'b0;
      bidir_pin_a_oe_out <= 1'b0;
      bidir_pin_b_out <= 1'b0;
      bidir_pin_b_oe_out <= 1'b0;
      dedicated_out_pin_out <= 1'b0;
      dedicated_out_pin_oe_out <= 1'b0;
      dedicated_out_pin_weak_out <= 1'b0;
      chip_select_n_out <= 1'b1;
      control_clock_out <= 1'b0;
      primary_data_in2_out <= 1'b0;
      primary_bitclk_out <= 1'b0;
      primary_framesync_out <= 1'b0;
    end else begin
      bidir_pin_a_out <= bidir_a_out_level;
      bidir_pin_a_oe_out <= (bidir_a_function_sel_in == `GSR_FUNC_GPO);
      bidir_pin_b_out <= bidir_b_out_level;
      bidir_pin_b_oe_out <= (bidir_b_function_sel_in == `GSR_FUNC_GPO);
      dedicated_out_pin_out <= next_out;
      dedicated_out_pin_oe_out <= next_oe;
      dedicated_out_pin_weak_out <= next_weak;
      chip_select_n_out <= spi_mode_in ? in_sync : 1'b1;
      control_clock_out <= next_control_clock;
      primary_data_in2_out <= next_din2;
      primary_bitclk_out <= primary_bitclk_source ? secondary_bitclk_in : bclk_sync;
      primary_framesync_out <= primary_framesync_source ? secondary_framesync_in
        : fsync_sync;
    end
  end

endmodule

/* dv/gsr_gpio_routing_props.sv */
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module gsr_gpio_routing_props (
  // clock, reset and register port
  input wire clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // selections
  input wire spi_mode_in,
  input wire spi_sdo_in,
  input wire [3:0] bidir_a_function_sel_in,
  input wire secondary_bitclk_in,
  input wire secondary_framesync_in,
  // pin and routed outputs
  input wire bidir_pin_a_out,
  input wire bidir_pin_a_oe_out,
  input wire dedicated_out_pin_out,
  input wire dedicated_out_pin_oe_out,
  input wire dedicated_out_pin_weak_out,
  input wire chip_select_n_out,
  input wire primary_bitclk_out,
  input wire primary_framesync_out
);
  reg [7:0] m_cfg;
  reg [2:0] m_val;
  reg [1:0] m_rt;
  // shadow of stored fields, rebuilt from writes so the checker needs no internals
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      m_cfg <= 8'h00;
      m_val <= 3'h0;
      m_rt <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h0C)
        m_cfg <= reg_wdata_in;
      if (reg_addr_in == 8'h0E)
        m_val <= reg_wdata_in[7:5];
      if (reg_addr_in == 8'h0F)
        m_rt <= reg_wdata_in[1:0];
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // output pin in plain general-output use
  sequence s_gpo_sel;
    !spi_mode_in && m_cfg[7:4] == 4'h2;
  endsequence
  AST_A_OE_ON: assert property (bidir_a_function_sel_in == 4'h2 |=> bidir_pin_a_oe_out)
    else $error("pin a not driven as output");
  AST_A_OE_OFF: assert property (bidir_a_function_sel_in != 4'h2 |=> !bidir_pin_a_oe_out)
    else $error("pin a driven while not output");
  AST_A_LEVEL: assert property (bidir_pin_a_out == $past(m_val[2]))
    else $error("pin a level differs from value bit");
  AST_CS_IDLE: assert property (!spi_mode_in |=> chip_select_n_out)
    else $error("chip select active outside spi mode");
  AST_SPI_SDO: assert property (spi_mode_in |=> dedicated_out_pin_oe_out
    && dedicated_out_pin_out == $past(spi_sdo_in)) else $error("spi data out wrong");
  AST_GPO_PUSH: assert property (s_gpo_sel ##0 m_cfg[2:0] == 3'h1 |=>
    dedicated_out_pin_oe_out && dedicated_out_pin_out == $past(m_val[0]))
    else $error("output pin level wrong");
  AST_DRV_HIZ: assert property (s_gpo_sel ##0 m_cfg[2:0] == 3'h0 |=>
    !dedicated_out_pin_oe_out && !dedicated_out_pin_weak_out) else $error("hi-z drives");
  AST_BCLK_SEC: assert property (m_rt[1] |=> primary_bitclk_out == $past(secondary_bitclk_in))
    else $error("bit clock not from secondary");
  AST_FS_SEC: assert property (m_rt[0] |=> primary_framesync_out == $past(secondary_framesync_in))
    else $error("frame sync not from secondary");
  AST_RT_RSVD: assert property (reg_rd_in && reg_addr_in == 8'h0F |=> !reg_rdata_out[7])
    else $error("routing reserved bit set");
endmodule

bind gsr_gpio_routing gsr_gpio_routing_props props (.clk_in(clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .spi_mode_in(spi_mode_in),
  .spi_sdo_in(spi_sdo_in), .bidir_a_function_sel_in(bidir_a_function_sel_in),
  .secondary_bitclk_in(secondary_bitclk_in), .secondary_framesync_in(secondary_framesync_in),
  .bidir_pin_a_out(bidir_pin_a_out), .bidir_pin_a_oe_out(bidir_pin_a_oe_out),
  .dedicated_out_pin_out(dedicated_out_pin_out),
  .dedicated_out_pin_oe_out(dedicated_out_pin_oe_out),
  .dedicated_out_pin_weak_out(dedicated_out_pin_weak_out),
  .chip_select_n_out(chip_select_n_out), .primary_bitclk_out(primary_bitclk_out),
  .primary_framesync_out(primary_framesync_out));

/* dv/gsr_pin_model.sv */
`timescale 1ns/1ps
// ------------------------------
// board side of the two bidirectional pins
// ------------------------------
module gsr_pin_model (
  // device drive
  input wire a_out_in,
  input wire a_oe_in,
  input wire b_out_in,
  input wire b_oe_in,
  // board driver levels
  input wire a_ext_in,
  input wire b_ext_in,
  // resolved wire levels
  output wire pin_a_out,
  output wire pin_b_out
);
  // device wins while it drives; board driver otherwise, so no stale level lingers
  assign pin_a_out = a_oe_in ? a_out_in : a_ext_in;
  assign pin_b_out = b_oe_in ? b_out_in : b_ext_in;
endmodule

/* dv/gsr_gpio_routing_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module gsr_gpio_routing_tb_top;
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic [7:0] ra = 8'h00, wd = 8'h00, rdat;
  logic wr = 1'h0, rd = 1'h0, spi = 1'h0, sdo = 1'h0;
  logic [3:0] fa = 4'h0, fb = 4'h0;
  logic [15:0] fsrc = 16'h0020;
  logic [4:0] src = 5'h00;
  logic bpin = 1'h0, fpin = 1'h0, sbc = 1'h0, sfs = 1'h0;
  logic ao, aoe, bo, boe, pa, pb, oo, ooe, ow, csn, cc, d2, pbc, pfs;
  int miscompares = 0, checked = 0;
  gsr_gpio_routing dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .spi_mode_in(spi),
    .spi_sdo_in(sdo), .bidir_a_function_sel_in(fa), .bidir_b_function_sel_in(fb),
    .outpin_func_src_in(fsrc), .bidir_pin_a_in(pa), .bidir_pin_a_out(ao),
    .bidir_pin_a_oe_out(aoe), .bidir_pin_b_in(pb), .bidir_pin_b_out(bo),
    .bidir_pin_b_oe_out(boe), .dedicated_out_pin_out(oo), .dedicated_out_pin_oe_out(ooe),
    .dedicated_out_pin_weak_out(ow), .dedicated_in_pin_in(src[2]), .chip_select_n_out(csn),
    .bitclk_pin_in(bpin), .framesync_pin_in(fpin), .dout_pin_in(src[3]),
    .primary_din_pin_in(src[4]), .secondary_bitclk_in(sbc), .secondary_framesync_in(sfs),
    .control_clock_out(cc), .primary_data_in2_out(d2), .primary_bitclk_out(pbc),
    .primary_framesync_out(pfs));
  gsr_pin_model model (.a_out_in(ao), .a_oe_in(aoe), .b_out_in(bo), .b_oe_in(boe),
    .a_ext_in(src[0]), .b_ext_in(src[1]), .pin_a_out(pa), .pin_b_out(pb));
  // ------------------------------
  // register access and helpers
  // ------------------------------
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    ra = a;
    wd = d;
    wr = 1'h1;
    @(negedge clk_in);
    wr = 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    ra = a;
    rd = 1'h1;
    @(negedge clk_in);
    rd = 1'h0;
    `CHK("rdata", e, rdat)
  endtask
  // pin changes pass four flops plus an output flop
  task automatic settle();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs();
    // reserved bits are written only with their reset value
    wreg(8'h0C, 8'h27);
    rchk(8'h0C, 8'h27);
    wreg(8'h0D, 8'h02);
    rchk(8'h0D, 8'h02);
    wreg(8'h0F, 8'h77);
    rchk(8'h0F, 8'h77);
    wreg(8'h0E, 8'hE0);
    rchk(8'h0E, 8'hE0);
    wreg(8'h0E, 8'h00);
    rchk(8'h20, 8'h00);
  endtask
  task automatic t_mon();
    fa = 4'h1;
    fb = 4'h2;
    src = 5'h07;
    wreg(8'h0D, 8'h02);
    settle();
    rchk(8'h0E, 8'h0A);
    fb = 4'h1;
    settle();
    rchk(8'h0E, 8'h0E);
    spi = 1'h1;
    sdo = 1'h1;
    settle();
    rchk(8'h0E, 8'h0C);
    `CHK("cs_n", 1'h1, csn)
    `CHK("sdo", 1'h1, oo & ooe)
    src = 5'h03;
    settle();
    `CHK("cs_n", 1'h0, csn)
    spi = 1'h0;
    wreg(8'h0D, 8'h00);
    src = 5'h07;
    settle();
    rchk(8'h0E, 8'h0C);
  endtask
  task automatic t_bidir();
    fa = 4'h2;
    fb = 4'h2;
    wreg(8'h0E, 8'h80);
    repeat (3) @(negedge clk_in);
    `CHK("a", 2'h3, {aoe, ao})
    `CHK("b", 2'h2, {boe, bo})
    wreg(8'h0E, 8'h40);
    repeat (3) @(negedge clk_in);
    `CHK("a", 1'h0, ao)
    `CHK("b", 1'h1, bo)
  endtask
  task automatic t_drive();
    logic eo, ew, l;
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 2; k++) begin
        l = k[0];
        eo = 1'h0;
        ew = 1'h0;
        case (c)
          1: eo = 1'h1;
          2: begin eo = !l; ew = l; end
          3: eo = !l;
          4: begin eo = l; ew = !l; end
          5: eo = l;
          default: ;
        endcase
        wreg(8'h0E, {2'h0, l, 5'h00});
        wreg(8'h0C, 8'(8'h20 | c));
        repeat (2) @(negedge clk_in);
        `CHK("oe", eo, ooe)
        `CHK("weak", ew, ow)
        if (eo | ew) `CHK("out", l, oo)
      end
    end
    wreg(8'h0C, 8'h50);
    repeat (2) @(negedge clk_in);
    `CHK("serial", 2'h3, {ooe, oo})
    // disabled function releases the pin whatever the drive field says
    wreg(8'h0C, 8'h01);
    repeat (2) @(negedge clk_in);
    `CHK("off", 2'h0, {ooe, ow})
  endtask
  task automatic t_route();
    fa = 4'h1;
    fb = 4'h1;
    wreg(8'h0D, 8'h02);
    for (int c = 1; c < 6; c++) begin
      wreg(8'h0F, 8'(((c < 4) ? (c << 5) : 0) | (c << 2)));
      src = 5'(1 << (c - 1));
      settle();
      `CHK("control_clock", 1'(c < 4), cc)
      `CHK("din2", 1'h1, d2)
      src = ~src;
      settle();
      `CHK("control_clock", 1'h0, cc)
      `CHK("din2", 1'h0, d2)
    end
    bpin = 1'h1;
    sfs = 1'h1;
    wreg(8'h0F, 8'h00);
    settle();
    `CHK("bclk", 2'h2, {pbc, pfs})
    wreg(8'h0F, 8'h03);
    settle();
    `CHK("fsync", 2'h1, {pbc, pfs})
  endtask
  // ------------------------------
  // clock, watchdog and main sequence
  // ------------------------------
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #5000000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1'h1;
    for (int i = 12; i < 16; i++) rchk(8'(i), 8'h00);
    t_regs();
    t_mon();
    t_bidir();
    t_drive();
    t_route();
    print_verdict();
  end
endmodule
